// file: rtl/adrl_channel.sv
/*
 * One output channel: slew-limited applied duty and its 255-slot PWM.
 * Assumes target and update strobe come from logic on the same clock.
 */
`timescale 1ns/1ns
module adrl_channel (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_update,
  input wire logic [7:0] i_target,
  input wire logic i_enable,
  input wire logic [2:0] i_step_sel,
  input wire logic i_slow,
  output logic [7:0] o_duty,
  output logic o_pwm
);

  logic [7:0] duty_ff;
  logic [7:0] nxt_duty;
  logic [1:0] slow_cnt_ff;
  logic [7:0] slot_ff;
  logic pwm_ff;
  logic [7:0] step;
  logic [7:0] diff_up;
  logic [7:0] diff_dn;
  logic ramp_ok;
  logic [1:0] nxt_slow_cnt;

  // Assertions below all share this clock and reset
  default clocking adrl_ch_cb @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);

  // Slow mode only moves on every fourth update
  assign ramp_ok = !i_slow || (slow_cnt_ff == 2'h0);
  assign nxt_slow_cnt = (slow_cnt_ff == 2'(adrl_pkg::SLOW_FACTOR - 1)) ?
    2'h0 : 2'(slow_cnt_ff + 2'h1);
  assign step = adrl_pkg::step_of(i_step_sel);
  assign diff_up = i_target - duty_ff;
  assign diff_dn = duty_ff - i_target;

  // Next duty: clamp at target so a step never overshoots
  always_comb begin
    nxt_duty = duty_ff;
    if (!i_enable) begin
      nxt_duty = i_target;
    end else if (!ramp_ok) begin
      nxt_duty = duty_ff;
    end else if (i_target > duty_ff) begin
      nxt_duty = (diff_up < step) ? i_target
                                  : 8'(duty_ff + step);
    end else if (i_target < duty_ff) begin
      nxt_duty = (diff_dn < step) ? i_target
                                  : 8'(duty_ff - step);
    end
  end

  // Stored duty is the reference for the next compare
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      duty_ff <= adrl_pkg::DUTY_RESET;
      slow_cnt_ff <= 2'h0;
    end else if (i_update) begin
      duty_ff <= nxt_duty;
      slow_cnt_ff <= (i_slow && i_enable) ? nxt_slow_cnt : 2'h0;
    end
  end

  // 255-slot period counter and comparator
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      slot_ff <= 8'h00;
      pwm_ff <= 1'b0;
    end else begin
      slot_ff <= (slot_ff == 8'(adrl_pkg::SLOTS_PER_PERIOD - 1)) ? 8'h00
                 : 8'(slot_ff + 8'h01);
      pwm_ff <= (slot_ff < duty_ff);
    end
  end

  assign o_duty = duty_ff;
  assign o_pwm = pwm_ff;

  a_no_overshoot_up: assert property (
    (i_update && i_enable && i_target > duty_ff) |=>
      (duty_ff <= $past(i_target) && duty_ff > $past(duty_ff)
       || $past(!ramp_ok)))
    else $error("ramp up overshoot or stall");
  a_no_overshoot_dn: assert property (
    (i_update && i_enable && ramp_ok && i_target < duty_ff) |=>
      (duty_ff >= $past(i_target) && duty_ff < $past(duty_ff)))
    else $error("ramp down overshoot or stall");
  a_step_bounded: assert property (
    (i_update && i_enable && ramp_ok && i_target != duty_ff) |=>
      ((duty_ff == $past(i_target)) ||
       (duty_ff - $past(duty_ff) == $past(step)) ||
       ($past(duty_ff) - duty_ff == $past(step))))
    else $error("step size wrong");
  a_direct_apply: assert property (
    (i_update && !i_enable) |=> duty_ff == $past(i_target))
    else $error("disabled channel not direct");
  a_hold_no_update: assert property (
    !i_update |=> $stable(duty_ff))
    else $error("duty changed without update");
  a_equal_no_change: assert property (
    (i_update && i_target == duty_ff) |=> $stable(duty_ff))
    else $error("duty moved at equal target");
  a_slot_wrap: assert property (
    slot_ff == 8'hfe |=> slot_ff == 8'h00)
    else $error("period not 255 slots");
  a_slow_hold: assert property (
    (i_update && i_enable && i_slow && slow_cnt_ff != 2'h0) |=>
      $stable(duty_ff))
    else $error("slow mode moved early");
  c_ramp_up: cover property (@(posedge i_clk)
    i_update && i_enable && i_target > duty_ff);
  c_ramp_dn: cover property (@(posedge i_clk)
    i_update && i_enable && i_target < duty_ff);
  c_slow: cover property (@(posedge i_clk) i_update && i_slow && i_enable);

endmodule : adrl_channel

// file: rtl/adrl_pkg.sv
/*
 * Shared constants for the acoustic duty ramp limiter: register offsets,
 * field positions, reset values and the step lookup.
 * Assumes an 8-bit register port with byte-wide offsets.
 */
package adrl_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_ACOUSTIC_FIRST = 8'h62;
  localparam logic [7:0] ADDR_ACOUSTIC_SECOND = 8'h63;
  localparam logic [7:0] ADDR_SLOW_CFG = 8'h64;
  localparam logic [7:0] ADDR_DUTY_FIRST = 8'h65;
  localparam logic [7:0] ADDR_DUTY_SECOND = 8'h66;
  localparam logic [7:0] ADDR_DUTY_THIRD = 8'h67;

  // Field positions
  localparam int EN_FIRST_BIT = 3;
  localparam int EN_SECOND_BIT = 7;
  localparam int EN_THIRD_BIT = 3;
  localparam int SEL_FIRST_LSB = 0;
  localparam int SEL_SECOND_LSB = 4;
  localparam int SEL_THIRD_LSB = 0;

  // Reset values
  localparam logic [7:0] ACOUSTIC_RESET = 8'h00;
  localparam logic [2:0] SLOW_RESET = 3'h0;
  localparam logic [7:0] DUTY_RESET = 8'h00;

  // Timing
  localparam int SLOTS_PER_PERIOD = 255;
  localparam int SLOW_FACTOR = 4;

  // Step size in slots for a three-bit rate code
  function automatic logic [7:0] step_of(input logic [2:0] code);
    logic [7:0] s;
    s = 8'h01;
    case (code)
      3'h0: s = 8'h01;
      3'h1: s = 8'h02;
      3'h2: s = 8'h03;
      3'h3: s = 8'h05;
      3'h4: s = 8'h08;
      3'h5: s = 8'h0c;
      3'h6: s = 8'h18;
      default: s = 8'h30;
    endcase
    return s;
  endfunction : step_of

endpackage : adrl_pkg

// file: rtl/adrl_top.sv
/*
 * Acoustic duty ramp limiter: registers and three ramped PWM channels.
 * Assumes targets and update strobe come from the fan control loop on
 * i_clk, and a simple same-clock register port.
 */
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ns
module adrl_top (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_update,
  input wire logic [7:0] i_target_first,
  input wire logic [7:0] i_target_second,
  input wire logic [7:0] i_target_third,
  output logic o_fan_drive_first,
  output logic o_fan_drive_second,
  output logic o_fan_drive_third
);

  logic [7:0] acoustic_first_ff;
  logic [7:0] acoustic_second_ff;
  logic [2:0] slow_ff;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic [7:0] duty_first;
  logic [7:0] duty_second;
  logic [7:0] duty_third;
  logic [2:0] en;
  logic [2:0] sel_first;
  logic [2:0] sel_second;
  logic [2:0] sel_third;

  // Assertions below all share this clock and reset
  default clocking adrl_top_cb @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);

  // Per-output enable and rate fields
  assign en[0] = acoustic_first_ff[adrl_pkg::EN_FIRST_BIT];
  assign en[1] = acoustic_second_ff[adrl_pkg::EN_SECOND_BIT];
  assign en[2] = acoustic_second_ff[adrl_pkg::EN_THIRD_BIT];
  assign sel_first =
    acoustic_first_ff[adrl_pkg::SEL_FIRST_LSB +: 3];
  assign sel_second =
    acoustic_second_ff[adrl_pkg::SEL_SECOND_LSB +: 3];
  assign sel_third =
    acoustic_second_ff[adrl_pkg::SEL_THIRD_LSB +: 3];

  // Register writes; unmapped writes are dropped
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      acoustic_first_ff <= adrl_pkg::ACOUSTIC_RESET;
      acoustic_second_ff <= adrl_pkg::ACOUSTIC_RESET;
      slow_ff <= adrl_pkg::SLOW_RESET;
    end else if (i_wr) begin
      if (i_addr == adrl_pkg::ADDR_ACOUSTIC_FIRST) begin
        acoustic_first_ff <= i_wdata;
      end
      if (i_addr == adrl_pkg::ADDR_ACOUSTIC_SECOND) begin
        acoustic_second_ff <= i_wdata;
      end
      if (i_addr == adrl_pkg::ADDR_SLOW_CFG) begin
        slow_ff <= i_wdata[2:0];
      end
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    nxt_rdata = 8'h00;
    case (i_addr)
      adrl_pkg::ADDR_ACOUSTIC_FIRST: nxt_rdata = acoustic_first_ff;
      adrl_pkg::ADDR_ACOUSTIC_SECOND: nxt_rdata = acoustic_second_ff;
      adrl_pkg::ADDR_SLOW_CFG: nxt_rdata = {5'h00, slow_ff};
      adrl_pkg::ADDR_DUTY_FIRST: nxt_rdata = duty_first;
      adrl_pkg::ADDR_DUTY_SECOND: nxt_rdata = duty_second;
      adrl_pkg::ADDR_DUTY_THIRD: nxt_rdata = duty_third;
      default: nxt_rdata = 8'h00;
    endcase
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= i_rd ? nxt_rdata : 8'h00;
    end
  end
  assign o_rdata = rdata_ff;

  // Independent channels so shared targets can ramp differently
  adrl_channel u_first (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_update(i_update),
    .i_target(i_target_first),
    .i_enable(en[0]),
    .i_step_sel(sel_first),
    .i_slow(slow_ff[0]),
    .o_duty(duty_first),
    .o_pwm(o_fan_drive_first)
  );
  adrl_channel u_second (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_update(i_update),
    .i_target(i_target_second),
    .i_enable(en[1]),
    .i_step_sel(sel_second),
    .i_slow(slow_ff[1]),
    .o_duty(duty_second),
    .o_pwm(o_fan_drive_second)
  );
  adrl_channel u_third (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_update(i_update),
    .i_target(i_target_third),
    .i_enable(en[2]),
    .i_step_sel(sel_third),
    .i_slow(slow_ff[2]),
    .o_duty(duty_third),
    .o_pwm(o_fan_drive_third)
  );

  // Enable and rate fields follow the last write to their register
  a_enable_first: assert property (
    (i_wr && i_addr == adrl_pkg::ADDR_ACOUSTIC_FIRST) |=>
      en[0] == $past(i_wdata[adrl_pkg::EN_FIRST_BIT]))
    else $error("first enable not written");
  a_enable_second: assert property (
    (i_wr && i_addr == adrl_pkg::ADDR_ACOUSTIC_SECOND) |=>
      en[1] == $past(i_wdata[adrl_pkg::EN_SECOND_BIT]))
    else $error("second enable not written");
  a_enable_third: assert property (
    (i_wr && i_addr == adrl_pkg::ADDR_ACOUSTIC_SECOND) |=>
      en[2] == $past(i_wdata[adrl_pkg::EN_THIRD_BIT]))
    else $error("third enable not written");
  a_sel_first: assert property (
    (i_wr && i_addr == adrl_pkg::ADDR_ACOUSTIC_FIRST) |=>
      sel_first == $past(i_wdata[2:0]))
    else $error("first rate field wrong");
  a_sel_second: assert property (
    (i_wr && i_addr == adrl_pkg::ADDR_ACOUSTIC_SECOND) |=>
      sel_second == $past(i_wdata[6:4]))
    else $error("second rate field wrong");
  a_sel_third: assert property (
    (i_wr && i_addr == adrl_pkg::ADDR_ACOUSTIC_SECOND) |=>
      sel_third == $past(i_wdata[2:0]))
    else $error("third rate field wrong");
  a_slow_written: assert property (
    (i_wr && i_addr == adrl_pkg::ADDR_SLOW_CFG) |=>
      slow_ff == $past(i_wdata[2:0]))
    else $error("slow bits not written");

  // Writes elsewhere, read-only duties too, leave the controls alone
  a_unmapped_keep: assert property (
    (i_wr && i_addr != adrl_pkg::ADDR_ACOUSTIC_FIRST
     && i_addr != adrl_pkg::ADDR_ACOUSTIC_SECOND
     && i_addr != adrl_pkg::ADDR_SLOW_CFG) |=>
      $stable(acoustic_first_ff) && $stable(acoustic_second_ff)
      && $stable(slow_ff))
    else $error("unmapped write changed a register");

  // Read data stands only in the slot after the strobe
  a_read_idle: assert property (
    !i_rd |=> o_rdata == 8'h00)
    else $error("read data outside read slot");
  a_read_duty: assert property (
    (i_rd && i_addr == adrl_pkg::ADDR_DUTY_FIRST) |=>
      o_rdata == $past(duty_first))
    else $error("applied duty read back wrong");

  // Duty ends give a steady drive, no stray slot at the wrap
  a_drive_off: assert property (
    duty_first == 8'h00 |=> !o_fan_drive_first)
    else $error("zero duty still drives");
  a_drive_full: assert property (
    duty_third == 8'hff |=> o_fan_drive_third)
    else $error("full duty drops a slot");
  c_read_duty: cover property (@(posedge i_clk)
    i_rd && i_addr == adrl_pkg::ADDR_DUTY_FIRST);
  c_all_on: cover property (@(posedge i_clk) &en);

endmodule : adrl_top

// file: test/adrl_fan_model.sv
/*
 * Fan model: counts how many of the last 255 clock samples of its drive
 * input were high, i.e. the high slots of one whole PWM period.
 * Assumes the drive is sampled on the block's own clock.
 */
`timescale 1ns/1ns
module adrl_fan_model (
  input wire logic i_clk,
  input wire logic i_pwm,
  output logic [8:0] o_high_slots
);
  logic [254:0] hist_ff;

  // Sliding window: any 255-cycle span of a periodic drive holds one period
  always_ff @(posedge i_clk) begin
    hist_ff <= {hist_ff[253:0], i_pwm};
  end

  // High slot count of the window
  assign o_high_slots = 9'($countones(hist_ff));
endmodule : adrl_fan_model

// file: test/adrl_top_bench.sv
/*
 * Self-checking bench for the ramp limiter: register port tasks, update
 * strobes, and fan models measuring each output's high slots.
 * Assumes the register map and reset values of the shared package.
 */
`timescale 1ns/1ns
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin \
  n_fail++; $display("unexpected at %0t: got %h want %h", $time, got, \
  exp); end end
module adrl_top_bench;
  logic i_clk, i_arst_n, i_wr, i_rd, i_update;
  logic [7:0] i_addr, i_wdata, o_rdata, i_t1, i_t2, i_t3;
  logic f1, f2, f3;
  logic [8:0] h1, h2, h3;
  int n_fail = 0;
  int checks = 0;
  logic [7:0] stepv [8] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h08, 8'h0c,
    8'h18, 8'h30};

  adrl_top dut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_update(i_update), .i_target_first(i_t1), .i_target_second(i_t2),
    .i_target_third(i_t3), .o_fan_drive_first(f1),
    .o_fan_drive_second(f2), .o_fan_drive_third(f3));
  adrl_fan_model fan1 (.i_clk(i_clk), .i_pwm(f1), .o_high_slots(h1));
  adrl_fan_model fan2 (.i_clk(i_clk), .i_pwm(f2), .o_high_slots(h2));
  adrl_fan_model fan3 (.i_clk(i_clk), .i_pwm(f3), .o_high_slots(h3));

  // 25 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr

  // Read data is looked at only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 `CHK(o_rdata, e)
  endtask : rd

  task automatic upd(input logic [7:0] a, input logic [7:0] b,
                     input logic [7:0] c);
    @(posedge i_clk);
    i_update <= 1'b1;
    i_t1 <= a;
    i_t2 <= b;
    i_t3 <= c;
    @(posedge i_clk);
    i_update <= 1'b0;
  endtask : upd

  task automatic duties(input logic [7:0] a, input logic [7:0] b,
                        input logic [7:0] c);
    rd(8'h65, a);
    rd(8'h66, b);
    rd(8'h67, c);
  endtask : duties

  task automatic test_done;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done

  // Watchdog: the whole sequence needs well under 2000 cycles
  initial begin
    repeat (2000) @(posedge i_clk);
    n_fail++;
    test_done;
  end

  initial begin
    {i_wr, i_rd, i_update, i_arst_n} = 4'h0;
    {i_addr, i_wdata, i_t1, i_t2, i_t3} = 40'h0;
    repeat (5) @(posedge i_clk);
    i_arst_n <= 1'b1;
    // Reset values, unmapped and read-only places
    rd(8'h62, 8'h00);
    rd(8'h63, 8'h00);
    rd(8'h64, 8'h00);
    wr(8'h70, 8'h5a);
    rd(8'h70, 8'h00);
    wr(8'h65, 8'h33);
    duties(8'h00, 8'h00, 8'h00);
    $display("test reset done");
    // Disabled outputs take the target at once, PWM shows it
    upd(8'd100, 8'd50, 8'd255);
    duties(8'd100, 8'd50, 8'd255);
    repeat (260) @(posedge i_clk);
    // Look after the edge so the window has settled
    #1;
    `CHK(h1, 9'd100)
    `CHK(h2, 9'd50)
    `CHK(h3, 9'd255)
    $display("test direct done");
    // Every step code, one rising step from zero
    for (int k = 0; k < 8; k++) begin
      wr(8'h62, 8'h00);
      upd(8'h00, 8'h00, 8'h00);
      wr(8'h62, 8'h08 | 8'(k));
      rd(8'h62, 8'h08 | 8'(k));
      upd(8'd200, 8'h00, 8'h00);
      rd(8'h65, stepv[k]);
    end
    // Step 48 climbs, then clamps at the target and holds
    for (int k = 2; k < 5; k++) begin
      upd(8'd200, 8'h00, 8'h00);
      rd(8'h65, 8'(48 * k));
    end
    upd(8'd200, 8'h00, 8'h00);
    rd(8'h65, 8'd200);
    upd(8'd200, 8'h00, 8'h00);
    rd(8'h65, 8'd200);
    $display("test rise done");
    // Falling steps of 8, then a short rise lands on the target
    wr(8'h62, 8'h0c);
    upd(8'h00, 8'h00, 8'h00);
    rd(8'h65, 8'd192);
    upd(8'h00, 8'h00, 8'h00);
    rd(8'h65, 8'd184);
    upd(8'd190, 8'h00, 8'h00);
    rd(8'h65, 8'd190);
    $display("test fall done");
    // Outputs two and three ramp at their own rates, one goes direct
    wr(8'h63, 8'hd9);
    rd(8'h63, 8'hd9);
    wr(8'h62, 8'h00);
    upd(8'd100, 8'd100, 8'd100);
    duties(8'd100, 8'd12, 8'd2);
    duties(8'd100, 8'd12, 8'd2);
    $display("test independent done");
    // Slow mode: only one update in four moves the duty
    wr(8'h64, 8'hff);
    rd(8'h64, 8'h07);
    wr(8'h62, 8'h0c);
    for (int k = 0; k < 5; k++) begin
      upd(8'd200, 8'd100, 8'd100);
      rd(8'h65, (k < 4) ? 8'd108 : 8'd116);
      rd(8'h66, (k < 4) ? 8'd24 : 8'd36);
      rd(8'h67, (k < 4) ? 8'd4 : 8'd6);
    end
    $display("test slow done");
    test_done;
  end
endmodule : adrl_top_bench
